//--- src/wwdt_top.sv
// Window watchdog: downcounter, window check, activation and halt handling
//
// Behaviour
// R1: The counter decrements once every 16384 internal oscillator clocks via a prescaler.
// R2: When active and the counter goes from 40h to 3Fh, a reset pulse of about 30 us is issued.
// R3: A counter reload while the counter exceeds the window limit issues a reset.
// R4: In software mode the watchdog is off after reset, set on by the activate bit, sticky.
// R5: With the hardware option the watchdog is always active and the activate bit is ignored.
// R6: The counter keeps counting down even when the watchdog is inactive.
// R7: Software writes values between FFh and C0h so the top bit is set on each refresh.
// R8: Software reloads only while the counter is below the window and above 3Fh.
// R9: The lower six counter bits give 64 programmable timeout steps.
// R10: A control write does not reset the prescaler.
// R11: A write setting the activate bit with the top bit clear resets at once.
// R12: When active with the halt-reset option, a halt instruction causes a reset.
// R13: Without halt reset, software should refresh the counter just before halting.
// R14: In plain halt the counter decrements once, then stops, with no reset until wake-up.
// R15: In active halt the counter does not decrement and resumes at once on wake-up.
// R16: The control register holds the activate bit in bit 7 and the counter in bits 6 to 0.
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Options and chip state
  input wire logic hw_watchdog_option,
  input wire logic halt_reset_option,
  input wire logic osc_interrupt_enable,
  input wire logic halt_exec,
  input wire logic wake_int,
  input wire logic osc_clk_en,
  // Reset outputs
  output logic wd_reset_req,
  output logic rst_pin_n
);

  wwdt_bus_t bus;
  wwdt_state_t state_q;
  logic [6:0] cnt_q;
  logic [6:0] win_q;
  logic act_q;
  logic [7:0] rdata_q;
  logic tick;
  logic active;
  logic ctrl_wr;
  logic win_wr;
  logic dec_en;
  logic dec;
  logic roll_rst;
  logic window_rst;
  logic soft_rst;
  logic halt_rst;
  logic rst_src_q;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign ctrl_wr = bus.wr && (bus.addr == WWDT_ADDR_CTRL);
  assign win_wr = bus.wr && (bus.addr == WWDT_ADDR_WIN);

  // ==========================================================================
  // Prescaler
  wwdt_prescaler u_presc
  (
    .clk(clk),
    .reset(reset),
    .osc_en(osc_clk_en),
    .tick(tick)
  );

  // ==========================================================================
  // Activation: sticky bit, overridden by the hardware option
  always_ff @(posedge clk)
  begin
    if (reset)
      act_q <= 1'b0;  // [R4]
    else if (ctrl_wr && bus.wdata[WWDT_ACT_BIT])
      act_q <= 1'b1;  // [R4]
  end

  assign active = act_q || hw_watchdog_option;  // [R5]

  // ==========================================================================
  // Halt handling: plain halt allows one decrement, active halt none
  always_ff @(posedge clk)
  begin
    if (reset)
      state_q <= WWDT_RUN;
    else
    begin
      case (state_q)
        WWDT_RUN:
        begin
          if (halt_exec && !(active && halt_reset_option))
            state_q <= osc_interrupt_enable ? WWDT_STOPPED : WWDT_HALT_ONE;  // [R14] [R15]
        end
        WWDT_HALT_ONE:
        begin
          if (wake_int)
            state_q <= WWDT_RUN;
          else if (tick)
            state_q <= WWDT_STOPPED;  // [R14]
        end
        WWDT_STOPPED:
        begin
          if (wake_int)
            state_q <= WWDT_RUN;  // [R15]
        end
        default:
          state_q <= WWDT_RUN;
      endcase
    end
  end

  // Decrements only run while not stopped
  assign dec_en = (state_q != WWDT_STOPPED);  // [R15]
  assign dec = tick && dec_en;

  // ==========================================================================
  // Reset sources; rollover is masked in both halt states, including the plain-halt single step
  assign roll_rst = active && dec && (cnt_q == WWDT_CNT_FLOOR)
                    && (state_q == WWDT_RUN);  // [R2]
  assign window_rst = active && ctrl_wr && (cnt_q > win_q);  // [R3]
  assign soft_rst = ctrl_wr && bus.wdata[WWDT_ACT_BIT]
                    && !bus.wdata[WWDT_TOP_BIT];  // [R11]
  assign halt_rst = (state_q == WWDT_RUN) && halt_exec && active
                    && halt_reset_option;  // [R12]
  assign wd_reset_req = roll_rst || window_rst || soft_rst || halt_rst;

  // ==========================================================================
  // Counter: a write loads it, otherwise it decrements freely
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_q <= WWDT_CNT_RESET;
    else if (ctrl_wr)
      cnt_q <= bus.wdata[6:0];  // [R16] [R9]
    else if (dec)
      cnt_q <= cnt_q - 7'h1;  // [R6] [R1]
  end

  // Window limit register
  always_ff @(posedge clk)
  begin
    if (reset)
      win_q <= WWDT_WIN_RESET;
    else if (win_wr)
      win_q <= bus.wdata[6:0];
  end

  // Last reset-request sticky status; a new request wins over the read clear
  always_ff @(posedge clk)
  begin
    if (reset)
      rst_src_q <= 1'b0;
    else if (wd_reset_req)
      rst_src_q <= 1'b1;
    else if (bus.rd && bus.addr == WWDT_ADDR_STAT)
      rst_src_q <= 1'b0;
  end

  // ==========================================================================
  // Read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_q <= 8'h0;
    else if (bus.rd)
    begin
      case (bus.addr)
        WWDT_ADDR_CTRL: rdata_q <= {act_q, cnt_q};  // [R16]
        WWDT_ADDR_WIN: rdata_q <= {1'b0, win_q};
        WWDT_ADDR_STAT: rdata_q <= {3'h0, state_q, active, rst_src_q};
        default: rdata_q <= 8'h0;
      endcase
    end
    else
      rdata_q <= 8'h0;
  end

  assign rdata = rdata_q;

  // ==========================================================================
  // Reset pin stretcher
  wwdt_reset_pulse u_pulse
  (
    .clk(clk),
    .reset(reset),
    .req(wd_reset_req),
    .rst_pin_n(rst_pin_n)
  );

  // ==========================================================================
  // Checks
  chk_roll_resets: assert property (@(posedge clk) disable iff (reset)
    (active && tick && state_q == WWDT_RUN && cnt_q == 7'h40 && !wr)
    |-> wd_reset_req ##1 (!rst_pin_n && cnt_q == 7'h3f))
    else $error("rollover did not reset");  // [R2]

  chk_window_reload: assert property (@(posedge clk) disable iff (reset)
    (active && ctrl_wr && cnt_q > win_q) |=> !rst_pin_n)
    else $error("early reload did not reset");  // [R3]

  chk_soft_reset: assert property (@(posedge clk) disable iff (reset)
    (ctrl_wr && wdata[7] && !wdata[6]) |-> wd_reset_req)
    else $error("software reset missing");  // [R11]

  chk_act_sticky: assert property (@(posedge clk) disable iff (reset)
    act_q |=> act_q)
    else $error("activate bit cleared");  // [R4]

  chk_hw_active: assert property (@(posedge clk) disable iff (reset)
    hw_watchdog_option |-> active)
    else $error("hardware option not active");  // [R5]

  chk_free_count: assert property (@(posedge clk) disable iff (reset)
    (tick && state_q == WWDT_RUN && !wr) |=> cnt_q == $past(cnt_q) - 7'h1)
    else $error("counter did not decrement");  // [R6]

  chk_write_load: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr |=> cnt_q == $past(wdata[6:0]))
    else $error("write did not load counter");  // [R16]

  chk_halt_reset: assert property (@(posedge clk) disable iff (reset)
    (state_q == WWDT_RUN && halt_exec && active && halt_reset_option) |-> wd_reset_req)
    else $error("halt did not reset");  // [R12]

  chk_active_halt: assert property (@(posedge clk) disable iff (reset)
    (state_q == WWDT_STOPPED && !wr) |=> cnt_q == $past(cnt_q))
    else $error("counter moved while stopped");  // [R15]

  chk_plain_halt: assert property (@(posedge clk) disable iff (reset)
    (state_q == WWDT_HALT_ONE && tick && !wake_int) |=> state_q == WWDT_STOPPED)
    else $error("plain halt did not stop");  // [R14]

  chk_pulse_len: assert property (@(posedge clk) disable iff (reset)
    $fell(rst_pin_n) |-> !rst_pin_n [*8])
    else $error("reset pulse too short");  // [R2]

endmodule

//--- src/wwdt_pkg.sv
// Package of constants and types for the window watchdog
package wwdt_pkg;

  // ==========================================================================
  // Register map
  localparam logic [1:0] WWDT_ADDR_CTRL = 2'h0;   // wd_control_reg
  localparam logic [1:0] WWDT_ADDR_WIN = 2'h1;    // window_limit_reg
  localparam logic [1:0] WWDT_ADDR_STAT = 2'h2;   // Status (read only)

  // ==========================================================================
  // Field positions and reset values
  localparam int WWDT_ACT_BIT = 7;
  localparam int WWDT_TOP_BIT = 6;
  localparam logic [6:0] WWDT_CNT_RESET = 7'h7f;
  localparam logic [6:0] WWDT_WIN_RESET = 7'h7f;
  localparam logic [6:0] WWDT_CNT_FLOOR = 7'h40;  // Lowest value with top bit set

  // ==========================================================================
  // Timing
  localparam int WWDT_CLK_MHZ = 100;
  localparam int WWDT_PRESCALE = 16384;           // Oscillator cycles per decrement
  localparam int WWDT_RST_PULSE_US = 30;
  localparam int WWDT_RST_CYCLES = WWDT_RST_PULSE_US * WWDT_CLK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [2:0]
  {
    WWDT_RUN = 3'b001,
    WWDT_HALT_ONE = 3'b010,
    WWDT_STOPPED = 3'b100
  } wwdt_state_t;

  typedef struct packed
  {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wwdt_bus_t;

endpackage

//--- src/wwdt_prescaler.sv
// Free-running prescaler producing one decrement tick per period
`timescale 1ns/1ps
module wwdt_prescaler
  import wwdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control and tick
  input wire logic osc_en,
  output logic tick
);

  logic [13:0] cnt_q;

  // ==========================================================================
  // Counter is never cleared by register writes, so timeouts jitter by one period
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_q <= 14'h0;
    else if (osc_en)
      cnt_q <= cnt_q + 14'h1;  // [R10]
  end

  assign tick = osc_en && (cnt_q == 14'(WWDT_PRESCALE - 1));  // [R1]

endmodule

//--- src/wwdt_reset_pulse.sv
// Stretches a one-cycle reset request into a timed low pulse on the reset pin
`timescale 1ns/1ps
module wwdt_reset_pulse
  import wwdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request and pin
  input wire logic req,
  output logic rst_pin_n
);

  logic [11:0] cnt_q;

  // ==========================================================================
  // Pulse length counter; a new request restarts the full length
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_q <= 12'h0;
    else if (req)
      cnt_q <= 12'(WWDT_RST_CYCLES);  // [R2]
    else if (cnt_q != 12'h0)
      cnt_q <= cnt_q - 12'h1;
  end

  assign rst_pin_n = (cnt_q == 12'h0);

endmodule

//--- bench/wwdt_top_tb.sv
// Self-checking bench for the window watchdog top
`timescale 1ns/1ps
module wwdt_top_tb;
  import wwdt_pkg::*;
  // ==========================================================================
  // Stimulus, observed outputs and counters
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hw_watchdog_option = 1'b0;
  logic halt_reset_option = 1'b0;
  logic osc_interrupt_enable = 1'b0;
  logic halt_exec = 1'b0;
  logic wake_int = 1'b0;
  logic osc_clk_en = 1'b1;
  logic [7:0] rdata;
  logic wd_reset_req;
  logic rst_pin_n;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int n = 0;

  // ==========================================================================
  // Device under test
  wwdt_top u_dut
  (
    .clk,
    .reset,
    .addr,
    .wdata,
    .wr,
    .rd,
    .rdata,
    .hw_watchdog_option,
    .halt_reset_option,
    .osc_interrupt_enable,
    .halt_exec,
    .wake_int,
    .osc_clk_en,
    .wd_reset_req,
    .rst_pin_n
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // Hang guard: whole run needs about 69k cycles, two prescaler periods go to halt
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================================
  // Helpers
  // Verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Counted comparison; case inequality so unknowns never match
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Synchronous reset held for two edges
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask

  // One-cycle write; the request line is combinational, so look inside the cycle
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d, input logic e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    #1 chk("reset request on write", {7'h00, e}, {7'h00, wd_reset_req});
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data stand only in the following cycle
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read data", e, rdata);
  endtask

  // Bounded wait for a reset request; n holds the cycles waited
  task automatic wait_req(input int lim);
    n = 0;
    while (n < lim && wd_reset_req !== 1'b1)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // Pin low from the cycle after the request for exactly the pulse length
  task automatic pin_chk();
    chk("pin at start", 8'h00, {7'h00, rst_pin_n});
    repeat (WWDT_RST_CYCLES - 1) @(posedge clk);
    #1 chk("pin at last low cycle", 8'h00, {7'h00, rst_pin_n});
    @(posedge clk);
    #1 chk("pin released", 8'h01, {7'h00, rst_pin_n});
  endtask

  // ==========================================================================
  // Scenarios
  initial
  begin
    // Reset values, unmapped place, window boundary, sticky activation
    do_reset();
    rd_reg(WWDT_ADDR_CTRL, {1'b0, WWDT_CNT_RESET});
    rd_reg(WWDT_ADDR_WIN, {1'b0, WWDT_WIN_RESET});
    wr_reg(2'h3, 8'hff, 1'b0);
    rd_reg(2'h3, 8'h00);
    wr_reg(WWDT_ADDR_WIN, 8'h50, 1'b0);
    rd_reg(WWDT_ADDR_WIN, 8'h50);
    wr_reg(WWDT_ADDR_CTRL, 8'h45, 1'b0);
    wr_reg(WWDT_ADDR_CTRL, 8'hc5, 1'b0);
    wr_reg(WWDT_ADDR_CTRL, 8'h45, 1'b0);
    rd_reg(WWDT_ADDR_CTRL, 8'hc5);
    wr_reg(WWDT_ADDR_WIN, 8'h45, 1'b0);
    wr_reg(WWDT_ADDR_CTRL, 8'hc5, 1'b0);
    wr_reg(WWDT_ADDR_WIN, 8'h44, 1'b0);
    wr_reg(WWDT_ADDR_CTRL, 8'hc5, 1'b1);
    // Software reset through a cleared top bit
    do_reset();
    wr_reg(WWDT_ADDR_CTRL, 8'h80, 1'b1);
    // Status shows run state, active and the request; reading clears the request flag
    rd_reg(WWDT_ADDR_STAT, 8'h07);
    rd_reg(WWDT_ADDR_STAT, 8'h06);
    // Reset on the halt instruction
    do_reset();
    halt_reset_option <= 1'b1;
    wr_reg(WWDT_ADDR_CTRL, 8'hff, 1'b0);
    @(posedge clk);
    halt_exec <= 1'b1;
    #1 chk("halt request", 8'h01, {7'h00, wd_reset_req});
    @(posedge clk);
    halt_exec <= 1'b0;
    halt_reset_option <= 1'b0;
    // Refresh, then active halt: a full prescaler period passes with no decrement
    do_reset();
    wr_reg(WWDT_ADDR_CTRL, 8'h40, 1'b0);
    @(posedge clk);
    osc_interrupt_enable <= 1'b1;
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    wait_req(16400);
    chk("active halt request", 8'h00, {7'h00, wd_reset_req});
    rd_reg(WWDT_ADDR_CTRL, 8'h40);
    rd_reg(WWDT_ADDR_STAT, 8'h10);
    // Wake, then plain halt: one decrement, then stopped; inactive so no reset
    @(posedge clk);
    wake_int <= 1'b1;
    osc_interrupt_enable <= 1'b0;
    @(posedge clk);
    wake_int <= 1'b0;
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    rd_reg(WWDT_ADDR_STAT, 8'h08);
    wait_req(16400);
    chk("inactive rollover", 8'h00, {7'h00, wd_reset_req});
    rd_reg(WWDT_ADDR_CTRL, 8'h3f);
    rd_reg(WWDT_ADDR_STAT, 8'h10);
    // A late write leaves the prescaler phase alone
    do_reset();
    repeat (8000) @(posedge clk);
    wr_reg(WWDT_ADDR_CTRL, 8'hc0, 1'b0);
    wait_req(9000);
    chk("decrement delay", 8'h01, {7'h00, n > 8370 && n < 8395});
    @(posedge clk) #1 pin_chk();
    // Hardware option: active with the activate bit clear
    do_reset();
    hw_watchdog_option <= 1'b1;
    wr_reg(WWDT_ADDR_CTRL, 8'h40, 1'b0);
    wait_req(16400);
    chk("forced watchdog rollover", 8'h01, {7'h00, wd_reset_req});
    finish_test();
  end
endmodule
